// [src/fuse_prog_pkg.sv]
// Constants, types and helpers of the supply pulse fuse programmer
//
// Behaviour
// - After a register is chosen, a high pulse enters its bitfield state.
// - Each mid pulse in the bitfield state adds one, stopping at maximum.
// - A supply cycle clears every intact location and keeps blown ones.
// - A high pulse in blow addressing blows the one addressed bit.
// - Blown bits stay set; more bits may be blown until locked.
// - Once the lock bit is blown, all further programming is rejected.
// - In trial mode high pulses keep cycling the selection states.
// - In mode select, one mid pulse picks blow, two pick trial.
// - Trial mode keeps several addressed values until supply cycles.
// - Trial mode never blows any fuse.
// - Blow mode addresses one register per power cycle, no decrement.
// - Power-up enters initial state, clears trial codes, ignores mids.
// - Mode select leaves for parameter select after two high pulses.
// - Mid pulse count in parameter select picks register one to five.
// - From parameter select, one high pulse enters the bitfield state.
// - Trial mode: high pulse in bitfield returns to parameter select.
// - Blow mode: bitfield left only by power cycle or blowing pulse.
// - Register five: code 16 calibration output, code 512 lock bit.
// - Sensitivity codes to 255 set gain; 256 is coarse duty bit.
package fuse_prog_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_ACTIVE_NS = 40000;
  localparam int MIN_PULSE_CYC =
    (T_ACTIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LEN_W = 12;

  // ==========================================================
  // Registers, keys and codes
  localparam int NUM_REGS = 5;
  localparam int CODE_W = 10;
  localparam int KEY_W = 3;
  localparam int WORDS_W = NUM_REGS * CODE_W;
  localparam logic [KEY_W-1:0] KEY_SENS = 3'h1;
  localparam logic [KEY_W-1:0] KEY_FINE = 3'h2;
  localparam logic [KEY_W-1:0] KEY_FREQ = 3'h3;
  localparam logic [KEY_W-1:0] KEY_NULL = 3'h4;
  localparam logic [KEY_W-1:0] KEY_CAL = 3'h5;
  localparam logic [KEY_W-1:0] KEY_SAT = 3'h7;
  localparam logic [KEY_W-1:0] MODE_KEY_BLOW = 3'h1;
  localparam logic [KEY_W-1:0] MODE_KEY_TRY = 3'h2;
  localparam logic [CODE_W-1:0] MAX_SENS = 10'h1ff;
  localparam logic [CODE_W-1:0] MAX_FINE = 10'h1ff;
  localparam logic [CODE_W-1:0] MAX_FREQ = 10'h03f;
  localparam logic [CODE_W-1:0] MAX_CAL = 10'h3ff;
  localparam int COARSE_DUTY_BIT = 8;
  localparam int CAL_BIT = 4;
  localparam int LOCK_BIT = 9;

  // ==========================================================
  // Register bus map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_VAL_SENS = 8'h08;
  localparam logic [7:0] ADDR_VAL_FINE = 8'h0c;
  localparam logic [7:0] ADDR_VAL_FREQ = 8'h10;
  localparam logic [7:0] ADDR_VAL_NULL = 8'h14;
  localparam logic [7:0] ADDR_VAL_CAL = 8'h18;
  localparam logic EN_RST = 1'b1;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Types
  typedef enum logic [4:0] {
    ST_INIT = 5'b00001,
    ST_MODE = 5'b00010,
    ST_PARAM = 5'b00100,
    ST_FIELD = 5'b01000,
    ST_HALT = 5'b10000
  } prog_state_e;

  typedef enum logic [1:0] {
    MODE_NONE = 2'h0,
    MODE_BLOW = 2'h1,
    MODE_TRY = 2'h2
  } mode_e;

  typedef enum logic [1:0] {
    LVL_LOW = 2'h0,
    LVL_MID = 2'h1,
    LVL_HIGH = 2'h2
  } level_e;

  // ==========================================================
  // Helpers
  function automatic logic [CODE_W-1:0] get_word(
    input logic [WORDS_W-1:0] v, input logic [KEY_W-1:0] k);
    get_word = '0;
    if (k >= KEY_SENS && k <= KEY_CAL) begin
      get_word = v[(int'(k) - 1) * CODE_W +: CODE_W];
    end
  endfunction

  function automatic logic [CODE_W-1:0] max_code(
    input logic [KEY_W-1:0] k);
    case (k)
      KEY_SENS: max_code = MAX_SENS;
      KEY_FINE: max_code = MAX_FINE;
      KEY_FREQ: max_code = MAX_FREQ;
      KEY_CAL: max_code = MAX_CAL;
      default: max_code = '0;
    endcase
  endfunction

  function automatic logic single_bit(input logic [CODE_W-1:0] c);
    single_bit = (c != '0) && ((c & (c - 10'h001)) == '0);
  endfunction

endpackage

// [src/fuse_bank.sv]
// Nonvolatile fuse array: one word of fuse bits per parameter register
`timescale 1ns/10ps
module fuse_bank
  import fuse_prog_pkg::*;
(
  input wire logic i_ref_clk, // System clock
  input wire logic i_clr, // Return die to unblown state
  input wire logic i_we, // Blow pulse, one cycle
  input wire logic [KEY_W-1:0] i_idx, // Register key 1 to 5
  input wire logic [CODE_W-1:0] i_bits, // Bits to blow
  output logic [WORDS_W-1:0] o_words // All fuse words, registered
);

  typedef struct packed {
    logic [WORDS_W-1:0] words;
  } bank_s;

  bank_s q;
  bank_s n;

  // ==========================================================
  // Fuse update
  // Blowing only ever ORs bits in, so only i_clr can clear bits
  always_comb begin
    n = q;
    if (i_clr) begin
      n.words = '0;
    end
    // A blow landing with a clear still sticks: the set wins
    if (i_we && i_idx >= KEY_SENS && i_idx <= KEY_CAL) begin
      n.words[(int'(i_idx) - 1) * CODE_W +: CODE_W] =
        n.words[(int'(i_idx) - 1) * CODE_W +: CODE_W] | i_bits;
    end
  end

  // No reset: fuses survive power cycles, unlike trial codes
  always_ff @(posedge i_ref_clk) begin
    q <= n;
  end

  assign o_words = q.words;

endmodule

// [src/supply_pulse_fuse_programmer.sv]
// Supply pulse decoder, trial codes, fuse blowing and register bus slave
`timescale 1ns/10ps
module supply_pulse_fuse_programmer
  import fuse_prog_pkg::*;
#(
  parameter int P_MIN_PULSE_CYC = MIN_PULSE_CYC
) (
  input wire logic i_ref_clk, // 40 MHz clock
  input wire logic i_rst, // Power-up reset, async, high
  input wire logic i_supply_mid, // Supply above mid threshold
  input wire logic i_supply_high, // Supply above high threshold
  output logic [7:0] o_sens_gain, // Gain code in effect
  output logic o_coarse_duty, // Unidirectional duty select
  output logic [8:0] o_fine_duty, // Fine duty code in effect
  output logic [5:0] o_carrier_frequency, // Carrier code in effect
  output logic o_cal_test, // Fixed half duty test output
  output logic o_locked, // Lock fuse blown
  input wire logic [7:0] i_awaddr, // Write address
  input wire logic i_awvalid, // Write address valid
  output logic o_awready, // Write address ready
  input wire logic [31:0] i_wdata, // Write data
  input wire logic [3:0] i_wstrb, // Write strobes
  input wire logic i_wvalid, // Write data valid
  output logic o_wready, // Write data ready
  output logic [1:0] o_bresp, // Write response
  output logic o_bvalid, // Write response valid
  input wire logic i_bready, // Write response ready
  input wire logic [7:0] i_araddr, // Read address
  input wire logic i_arvalid, // Read address valid
  output logic o_arready, // Read address ready
  output logic [31:0] o_rdata, // Read data
  output logic [1:0] o_rresp, // Read response
  output logic o_rvalid, // Read data valid
  input wire logic i_rready // Read data ready
);

  // ==========================================================
  // State
  typedef struct packed {
    prog_state_e st;
    mode_e mode;
    level_e lvl;
    logic [LEN_W-1:0] len;
    logic hcnt;
    logic [KEY_W-1:0] mkey;
    logic [KEY_W-1:0] pkey;
    logic [KEY_W-1:0] sel;
    logic [WORDS_W-1:0] trial;
    logic [WORDS_W-1:0] eff;
    logic locked;
    logic en;
    logic fwe;
    logic fclr;
    logic [KEY_W-1:0] fidx;
    logic [CODE_W-1:0] fbits;
    logic aw_held;
    logic w_held;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } prog_s;

  localparam prog_s PROG_RST = '{
    st: ST_INIT, mode: MODE_NONE, lvl: LVL_LOW, en: EN_RST,
    default: '0};

  prog_s q;
  prog_s n;
  logic [WORDS_W-1:0] fuse_words;
  logic lock_fuse;
  logic long_enough;
  logic ev_mid;
  logic ev_high;
  logic [CODE_W-1:0] cur;

  // ==========================================================
  // Fuse array
  fuse_bank u_fuse_bank (
    .i_ref_clk(i_ref_clk),
    .i_clr(q.fclr),
    .i_we(q.fwe),
    .i_idx(q.fidx),
    .i_bits(q.fbits),
    .o_words(fuse_words)
  );

  // Lock bit lives in register five
  assign lock_fuse = fuse_words[(int'(KEY_CAL) - 1) * CODE_W + LOCK_BIT];

  // ==========================================================
  // Pulse classifier
  // An excursion counts once, when the supply falls back below mid;
  // its class is the highest level seen. Short glitches are dropped so
  // supply noise during measurements cannot step the logic.
  assign long_enough = q.len >= LEN_W'(P_MIN_PULSE_CYC);
  assign ev_mid = q.en && !i_supply_mid && !i_supply_high &&
    long_enough && q.lvl == LVL_MID;
  assign ev_high = q.en && !i_supply_mid && !i_supply_high &&
    long_enough && q.lvl == LVL_HIGH;
  assign cur = get_word(q.trial, q.sel);

  // ==========================================================
  // Next state
  always_comb begin
    n = q;
    n.fwe = 1'b0;
    n.fclr = 1'b0;
    n.locked = lock_fuse;

    // Track the excursion level and its length
    if (i_supply_mid || i_supply_high) begin
      if (i_supply_high) begin
        n.lvl = LVL_HIGH;
      end else if (q.lvl == LVL_LOW) begin
        n.lvl = LVL_MID;
      end
      if (!long_enough) begin
        n.len = q.len + LEN_W'(1);
      end
    end else begin
      n.lvl = LVL_LOW;
      n.len = '0;
    end

    // Programming sequence
    case (q.st)
      // Mid pulses have no effect here
      ST_INIT: begin
        if (ev_high) begin
          n.st = ST_MODE;
          n.mkey = '0;
          n.hcnt = 1'b0;
        end
      end
      ST_MODE: begin
        if (ev_mid && q.mkey != KEY_SAT) begin
          n.mkey = q.mkey + KEY_W'(1);
        end
        if (ev_high) begin
          if (!q.hcnt) begin
            n.hcnt = 1'b1;
          end else begin
            n.pkey = '0;
            n.st = ST_PARAM;
            if (q.mkey == MODE_KEY_BLOW) begin
              n.mode = MODE_BLOW;
            end else if (q.mkey == MODE_KEY_TRY) begin
              n.mode = MODE_TRY;
            end else begin
              n.mode = MODE_NONE;
              n.st = ST_HALT;
            end
          end
        end
      end
      ST_PARAM: begin
        if (ev_mid && q.pkey != KEY_SAT) begin
          n.pkey = q.pkey + KEY_W'(1);
        end
        if (ev_high) begin
          // Unknown keys park the logic until the next supply cycle
          if (q.pkey >= KEY_SENS && q.pkey <= KEY_CAL) begin
            n.sel = q.pkey;
            n.st = ST_FIELD;
          end else begin
            n.st = ST_HALT;
          end
        end
      end
      ST_FIELD: begin
        // Increment only, saturating; null and locked stay put
        if (ev_mid && !q.locked && cur < max_code(q.sel)) begin
          n.trial[(int'(q.sel) - 1) * CODE_W +: CODE_W] =
            cur + CODE_W'(1);
        end
        if (ev_high) begin
          if (q.mode == MODE_TRY) begin
            // Back to register choice; the code just set stays
            n.pkey = '0;
            n.st = ST_PARAM;
          end else begin
            // One blow, then nothing until power is cycled
            n.st = ST_HALT;
            if (!q.locked && single_bit(cur)) begin
              n.fwe = 1'b1;
              n.fidx = q.sel;
              n.fbits = cur;
            end
          end
        end
      end
      ST_HALT: begin
        n.st = ST_HALT;
      end
      default: begin
        n.st = ST_INIT;
      end
    endcase

    // Values in effect: blown fuses OR the volatile code
    for (int k = 1; k <= NUM_REGS; k++) begin
      n.eff[(k - 1) * CODE_W +: CODE_W] =
        get_word(fuse_words, KEY_W'(k)) | get_word(q.trial, KEY_W'(k));
    end

    // Write channel: address and data taken in either order
    if (i_awvalid && o_awready) begin
      n.aw_held = 1'b1;
      n.awaddr = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      n.w_held = 1'b1;
      n.wdata = i_wdata;
      n.wstrb = i_wstrb;
    end
    if (q.aw_held && q.w_held && !q.bvalid) begin
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      case (q.awaddr)
        ADDR_CTRL: begin
          if (q.wstrb[0]) begin
            n.en = q.wdata[CTRL_EN_BIT];
            n.fclr = q.wdata[CTRL_CLR_BIT];
          end
        end
        // Read-only words accept and ignore writes
        ADDR_STATUS, ADDR_VAL_SENS, ADDR_VAL_FINE, ADDR_VAL_FREQ,
        ADDR_VAL_NULL, ADDR_VAL_CAL: begin
          n.bresp = RESP_OKAY;
        end
        default: begin
          n.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (q.bvalid && i_bready) begin
      n.bvalid = 1'b0;
    end

    // Read channel: one read in flight, data registered
    if (q.rvalid && i_rready) begin
      n.rvalid = 1'b0;
    end
    if (i_arvalid && o_arready) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = '0;
      case (i_araddr)
        ADDR_CTRL: begin
          n.rdata[CTRL_EN_BIT] = q.en;
        end
        ADDR_STATUS: begin
          n.rdata[4:0] = q.st;
          n.rdata[6:5] = q.mode;
          n.rdata[9:7] = q.sel;
          n.rdata[10] = q.locked;
        end
        ADDR_VAL_SENS: n.rdata[CODE_W-1:0] = get_word(q.eff, KEY_SENS);
        ADDR_VAL_FINE: n.rdata[CODE_W-1:0] = get_word(q.eff, KEY_FINE);
        ADDR_VAL_FREQ: n.rdata[CODE_W-1:0] = get_word(q.eff, KEY_FREQ);
        ADDR_VAL_NULL: n.rdata[CODE_W-1:0] = get_word(q.eff, KEY_NULL);
        ADDR_VAL_CAL: n.rdata[CODE_W-1:0] = get_word(q.eff, KEY_CAL);
        default: begin
          n.rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  // ==========================================================
  // Registers
  // Reset models power-up: trial codes go to zero
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= PROG_RST;
    end else begin
      q <= n;
    end
  end

  // ==========================================================
  // Outputs
  // Gain uses codes up to 255; bit 8 is the coarse duty bit
  assign o_sens_gain = q.eff[7:0];
  assign o_coarse_duty = q.eff[COARSE_DUTY_BIT];
  assign o_fine_duty = q.eff[CODE_W +: 9];
  assign o_carrier_frequency = q.eff[2 * CODE_W +: 6];
  assign o_cal_test = q.eff[4 * CODE_W + CAL_BIT];
  assign o_locked = q.locked;
  assign o_awready = !q.aw_held && !q.bvalid;
  assign o_wready = !q.w_held && !q.bvalid;
  assign o_bvalid = q.bvalid;
  assign o_bresp = q.bresp;
  assign o_arready = !q.rvalid;
  assign o_rvalid = q.rvalid;
  assign o_rdata = q.rdata;
  assign o_rresp = q.rresp;

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  a_init_mid_ignored: assert property (
    q.st == ST_INIT && ev_mid && !ev_high |=> q.st == ST_INIT)
    else $error("mid pulse moved the initial state");

  a_mode_two_highs: assert property (
    q.st == ST_MODE && ev_high && !q.hcnt |=> q.st == ST_MODE)
    else $error("mode state left after one high pulse");

  a_mode_key_pick: assert property (
    q.st == ST_MODE && ev_high && q.hcnt && q.mkey == MODE_KEY_TRY
    |=> q.mode == MODE_TRY && q.st == ST_PARAM)
    else $error("two mid pulses did not select trial mode");

  a_field_entry: assert property (
    q.st == ST_PARAM && ev_high && q.pkey >= KEY_SENS &&
    q.pkey <= KEY_CAL |=> q.st == ST_FIELD && q.sel == $past(q.pkey))
    else $error("high pulse did not enter the chosen bitfield");

  a_code_step: assert property (
    q.st == ST_FIELD && ev_mid && !q.locked && cur < max_code(q.sel)
    |=> cur == $past(cur) + CODE_W'(1))
    else $error("mid pulse did not add one to the code");

  a_code_cap: assert property (
    q.st == ST_FIELD |-> cur <= max_code(q.sel))
    else $error("code above register maximum");

  a_try_no_blow: assert property (
    q.mode == MODE_TRY |-> !q.fwe)
    else $error("fuse blown in trial mode");

  a_try_return: assert property (
    q.st == ST_FIELD && q.mode == MODE_TRY && ev_high
    |=> q.st == ST_PARAM && $stable(q.trial))
    else $error("trial return lost state or value");

  a_blow_single: assert property (
    q.st == ST_FIELD && q.mode == MODE_BLOW && ev_high && !q.locked &&
    single_bit(cur) |=> q.fwe && q.fbits == $past(cur) ##1 !q.fwe)
    else $error("single addressed bit not blown once");

  a_blow_exit: assert property (
    q.st == ST_FIELD && q.mode == MODE_BLOW && ev_high
    |=> q.st == ST_HALT [*3])
    else $error("blow mode bitfield left wrongly");

  a_fuse_sticks: assert property (
    q.fwe |=> (get_word(fuse_words, $past(q.fidx)) & $past(q.fbits))
    == $past(q.fbits))
    else $error("blown bit not kept in fuse word");

  a_lock_rejects: assert property (
    q.locked |=> $stable(q.trial) && !q.fwe)
    else $error("programming accepted after lock");

endmodule

// [test/supply_programmer.sv]
// Behavioural model of the external programmer on the supply pin
`timescale 1ns/10ps
module supply_programmer #(
  parameter int P_GAP = 6 // Low gap after each pulse, cycles
) (
  input wire logic i_ref_clk, // Bench clock
  output logic o_mid, // Supply above mid level
  output logic o_high // Supply above high level
);
  // ==========================================================
  // Pulse generator
  // Supply rests at the low level between excursions
  initial begin
    o_mid = 1'b0;
    o_high = 1'b0;
  end

  // High pulses pass through mid, so both comparators trip
  task automatic pulse(input logic hv, input int len);
    @(posedge i_ref_clk);
    o_mid <= 1'b1;
    o_high <= hv;
    repeat (len) @(posedge i_ref_clk); // Hold the level
    o_mid <= 1'b0;
    o_high <= 1'b0;
    repeat (P_GAP) @(posedge i_ref_clk); // Low gap, also after blow
  endtask
endmodule

// [test/tb.sv]
// Self-checking bench for the supply pulse fuse programmer
`timescale 1ns/10ps
module tb;
  import fuse_prog_pkg::*;
  localparam int LEN = 6;
  logic clk, rst, mid, hi;
  logic [7:0] awaddr, araddr, gain;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic cduty, cal, locked;
  logic [8:0] fine;
  logic [5:0] freq;
  int fails, n_compared;

  // ==========================================================
  // Clock, partner and design
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  supply_programmer #(.P_GAP(LEN)) u_prog (.i_ref_clk(clk), .o_mid(mid),
    .o_high(hi));

  // Short minimum pulse keeps the long code walks affordable
  supply_pulse_fuse_programmer #(.P_MIN_PULSE_CYC(4)) u_dut (
    .i_ref_clk(clk), .i_rst(rst), .i_supply_mid(mid),
    .i_supply_high(hi), .o_sens_gain(gain), .o_coarse_duty(cduty),
    .o_fine_duty(fine), .o_carrier_frequency(freq), .o_cal_test(cal),
    .o_locked(locked), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
    .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
    .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready));

  // ==========================================================
  // Checking and bus tasks
  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Address and data offered together, each dropped when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er = RESP_OKAY);
    logic done;
    done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        done = 1'b1;
        bready <= 1'b0;
        chk("bresp", 32'(er), 32'(bresp));
      end
    end
    // One edge between calls, so bready is never set twice at once
    @(posedge clk);
  endtask

  // Read one word and compare data and response
  task automatic rchk(input string n, input logic [7:0] a,
    input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
    logic done;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        done = 1'b1;
        rready <= 1'b0;
        chk(n, e, rdata);
        chk("rresp", 32'(er), 32'(rresp));
      end
    end
    // One edge between calls, so rready is never set twice at once
    @(posedge clk);
  endtask

  // ==========================================================
  // Pulse sequences
  task automatic mids(input int n);
    repeat (n) u_prog.pulse(1'b0, LEN);
  endtask

  task automatic hv();
    u_prog.pulse(1'b1, LEN);
  endtask

  // Initial state through mode and register keys into the bitfield
  task automatic sel(input int m, input int k);
    hv();
    mids(m);
    hv();
    hv();
    mids(k);
    hv();
  endtask

  // Power cycle; the fuse array has no reset and survives it
  task automatic pwr();
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    // Values in effect are registered one edge after release
    repeat (2) @(posedge clk);
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Watchdog sized well above the longest code walk
  initial begin
    repeat (80000) @(posedge clk);
    fails++;
    tally_and_finish();
  end

  // ==========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hf;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Unprogrammed die: clear the fuse array first
    axw(ADDR_CTRL, 32'h3);
    repeat (2) @(posedge clk);
    rchk("ctrl", ADDR_CTRL, 32'h1);
    rchk("unmapped", 8'h1c, 32'h0, RESP_SLVERR);
    mids(3);
    rchk("status", ADDR_STATUS, 32'h1);
    axw(8'h1c, 32'h0, RESP_SLVERR);
    // Decode switched off: a high pulse must not leave the initial state
    axw(ADDR_CTRL, 32'h0);
    hv();
    rchk("status", ADDR_STATUS, 32'h1);
    axw(ADDR_CTRL, 32'h1);
    // Mode key three names no mode: logic parks until power cycles
    hv();
    mids(3);
    hv();
    hv();
    rchk("status", ADDR_STATUS, 32'h10);
    pwr();
    rchk("status", ADDR_STATUS, 32'h1);
    $display("test init done");

    // Trial mode: several values held at once
    sel(2, 1);
    mids(3);
    u_prog.pulse(1'b0, 2);
    rchk("status", ADDR_STATUS, 32'hc8);
    hv();
    mids(2);
    hv();
    mids(2);
    rchk("status", ADDR_STATUS, 32'h148);
    hv();
    mids(4);
    hv();
    mids(2);
    rchk("sens", ADDR_VAL_SENS, 32'h3);
    rchk("fine", ADDR_VAL_FINE, 32'h2);
    chk("gain", 32'h3, 32'(gain));
    chk("fine out", 32'h2, 32'(fine));
    hv();
    mids(3);
    hv();
    mids(64);
    rchk("freq", ADDR_VAL_FREQ, 32'h3f);
    chk("freq out", 32'h3f, 32'(freq));
    hv();
    mids(1);
    hv();
    mids(256);
    chk("coarse", 32'h1, 32'(cduty));
    chk("gain", 32'h3, 32'(gain));
    pwr();
    rchk("sens", ADDR_VAL_SENS, 32'h0);
    rchk("fine", ADDR_VAL_FINE, 32'h0);
    $display("test trial done");

    // Blow mode: bit 2 then bit 0 of fine duty, code 5
    sel(1, 2);
    mids(4);
    hv();
    mids(2);
    rchk("fine", ADDR_VAL_FINE, 32'h4);
    pwr();
    rchk("fine", ADDR_VAL_FINE, 32'h4);
    sel(1, 2);
    mids(1);
    hv();
    pwr();
    chk("fine out", 32'h5, 32'(fine));
    sel(1, 1);
    mids(3);
    hv();
    pwr();
    rchk("sens", ADDR_VAL_SENS, 32'h0);
    $display("test blow done");

    // Calibration bit, then the lock bit last
    sel(1, 5);
    mids(16);
    hv();
    pwr();
    chk("cal", 32'h1, 32'(cal));
    sel(1, 5);
    mids(512);
    hv();
    pwr();
    chk("locked", 32'h1, 32'(locked));
    rchk("cal word", ADDR_VAL_CAL, 32'h210);
    sel(2, 2);
    mids(3);
    chk("fine out", 32'h5, 32'(fine));
    pwr();
    sel(1, 1);
    mids(1);
    hv();
    pwr();
    rchk("sens", ADDR_VAL_SENS, 32'h0);
    $display("test lock done");
    tally_and_finish();
  end
endmodule
